// *** ors_cfg.svh ***
`ifndef ORS_CFG_SVH
`define ORS_CFG_SVH
// register offsets (byte addresses, one word each)
`define ORS_OFF_OPERATION    8'h00
`define ORS_OFF_ON_OFF_CFG   8'h04
`define ORS_OFF_VOUT_CMD     8'h08
`define ORS_OFF_VOUT_TRIM    8'h0c
`define ORS_OFF_VOUT_MAX     8'h10
`define ORS_OFF_MARGIN_HIGH  8'h14
`define ORS_OFF_MARGIN_LOW   8'h18
`define ORS_OFF_OV_LIMIT     8'h1c
`define ORS_OFF_OV_RESP      8'h20
`define ORS_OFF_UV_LIMIT     8'h24
`define ORS_OFF_UV_RESP      8'h28
`define ORS_OFF_PG_ON        8'h2c
`define ORS_OFF_PG_OFF       8'h30
`define ORS_OFF_STATUS       8'h34
`define ORS_OFF_CLEAR        8'h38
`define ORS_OFF_TARGET       8'h3c
// on_off_config fields
`define ORS_ONOFF_PIN_BIT    0
`define ORS_ONOFF_CMD_BIT    1
`define ORS_ONOFF_POL_BIT    2
`define ORS_ONOFF_ALWAYS_BIT 3
`define ORS_ONOFF_RESET      4'h1
// operation fields: bit0 on, bits2:1 margin (0 none, 1 low, 2 high)
`define ORS_OP_ON_BIT        0
`define ORS_OP_MARGIN_LSB    1
`define ORS_OP_RESET         3'h0
// fault response codes: 0 continue, 1 delayed, 2 latch, 3 while present
`define ORS_RESP_RESET       2'h3
// status bits
`define ORS_ST_OV_BIT        0
`define ORS_ST_UV_BIT        1
`define ORS_ST_OVL_BIT       2
`define ORS_ST_UVL_BIT       3
`define ORS_ST_EN_BIT        4
`define ORS_ST_PG_BIT        5
`define ORS_ST_TRACK_BIT     6
// millivolt figures, per-mille scale factors, strap codes and the fault delay in microseconds
`define ORS_ABS_MAX_MV       16'd5500
`define ORS_MAX_PM           11'd1100
`define ORS_OV_PM            11'd1150
`define ORS_UV_PM            11'd850
`define ORS_MH_PM            11'd1050
`define ORS_ML_PM            11'd950
`define ORS_PGON_PM          11'd900
`define ORS_PGOFF_PM         11'd850
`define ORS_STRAP_OPEN       5'h1f
`define ORS_STRAP_TRACK      5'h10
`define ORS_DELAY_US         100
`endif

// *** ors_pkg.sv ***
package ors_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ors_bus_req_t;
    typedef enum logic [1:0] {ORS_CONT, ORS_DELAY, ORS_LATCH, ORS_WHILE} ors_resp_t;
    typedef enum {ORS_INIT, ORS_OFF, ORS_RAMP, ORS_CAL, ORS_ON} ors_state_t;
endpackage

// *** ors_supervisor.sv ***
// What this block does
// R1: enable source chosen by on/off config
// R2: pin polarity positive by default, configurable
// R3: strap code decodes to 16 levels
// R4: strap sampled only at power-up
// R5: open strap gives 0V; low strap tracks
// R6: written command overrides strap setpoint
// R7: margins default 5%, entered via operation
// R8: signed trim adds to command
// R9: clamp to min(5.5V, 110% nominal)
// R10: clamp on target, command stored unchanged
// R11: OV limit 115%, response selectable
// R12: four fault responses supported
// R13: default response: off while fault present
// R14: UV limit 85%, same responses
// R15: power good open drain, low in faults
// R16: power good needs 90% and calibration
// R17: power good drops below 85%
// R18: power good defined after initialization
// R19: sync clock stable before enabling; this block has no sync clock input and enables without waiting
// R20: stored command beats strap at power-up
// R21: delayed shutdown cancels if fault clears
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ors_cfg.svh"
module ors_supervisor #(
    parameter int CLK_MHZ    = 25,
    parameter int DELAY_CYC  = `ORS_DELAY_US * CLK_MHZ
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // register port
    input  wire ors_pkg::ors_bus_req_t bus_req,
    output logic [15:0]              bus_rdata,
    // strap and stored setpoint, sampled at power-up
    input  wire logic [4:0]          setpoint_strap_pin,
    input  wire logic                nvm_cmd_valid,
    input  wire logic [15:0]         nvm_cmd_mv,
    // remote on/off pin and measurements
    input  wire logic                on_off_pin,
    input  wire logic [15:0]         vout_meas_mv,
    input  wire logic                cal_done,
    input  wire logic                init_done,
    // regulator controls
    output logic                     output_enable,
    output logic [15:0]              target_mv,
    output logic                     track_mode,
    // power good open drain
    output logic                     power_good_output_o,
    output logic                     power_good_output_oe
);
    import ors_pkg::*;

    // the fault delay counter is only 16 bits wide
    if (CLK_MHZ < 1 || DELAY_CYC < 1 || DELAY_CYC > 65535) begin : g_bad_timing
        $error("ors_supervisor: unsupported timing parameters");
    end

    function automatic logic [15:0] scale_pm(input logic [15:0] mv, input logic [10:0] pm);
        logic [26:0] p;
        p = mv * pm;
        return 16'(p / 27'd1000);
    endfunction

    function automatic logic [15:0] strap_mv(input logic [3:0] code);
        case (code)
            4'h0: return 16'd600;   4'h1: return 16'd700;
            4'h2: return 16'd750;   4'h3: return 16'd800;
            4'h4: return 16'd850;   4'h5: return 16'd900;
            4'h6: return 16'd950;   4'h7: return 16'd1000;
            4'h8: return 16'd1050;  4'h9: return 16'd1100;
            4'ha: return 16'd1200;  4'hb: return 16'd1500;
            4'hc: return 16'd1800;  4'hd: return 16'd2500;
            4'he: return 16'd3300;  default: return 16'd5000;
        endcase
    endfunction

    ors_state_t  state_reg, state_next;
    logic [2:0]  op_reg;
    logic [3:0]  onoff_reg;
    logic [15:0] nom_reg, cmd_reg, trim_reg, max_reg, mh_reg, ml_reg;
    logic [15:0] ovl_reg, uvl_reg, pgon_reg, pgoff_reg;
    ors_resp_t   ovr_reg, uvr_reg;
    logic        track_reg, ov_latch_reg, uv_latch_reg, pg_reg, en_reg, cal_ok_reg;
    logic        req_on_reg, pg_oe_reg;
    logic [15:0] ov_cnt_reg, uv_cnt_reg, tgt_reg, rdata_reg;

    // strap decode
    wire logic        strap_open  = setpoint_strap_pin == `ORS_STRAP_OPEN;
    wire logic        strap_track = setpoint_strap_pin < `ORS_STRAP_TRACK;
    wire logic [15:0] strap_val   = strap_open ? 16'h0 : strap_mv(setpoint_strap_pin[3:0]); // R3 R5
    wire logic [15:0] load_nom    = nvm_cmd_valid ? nvm_cmd_mv : strap_val; // R20

    // enable source
    wire logic pin_on = on_off_pin ^ onoff_reg[`ORS_ONOFF_POL_BIT]; // R2
    wire logic cmd_on = op_reg[`ORS_OP_ON_BIT];
    wire logic req_on = onoff_reg[`ORS_ONOFF_ALWAYS_BIT] ||
                        ((!onoff_reg[`ORS_ONOFF_PIN_BIT] || pin_on) &&
                         (!onoff_reg[`ORS_ONOFF_CMD_BIT] || cmd_on)); // R1

    // target: margin or command plus trim, then clamp
    wire logic [1:0]  margin   = op_reg[2:1];
    wire logic [15:0] base_mv  = margin == 2'h2 ? mh_reg :
                                 margin == 2'h1 ? ml_reg : cmd_reg; // R7 R6
    wire logic [16:0] sum_mv   = {1'b0, base_mv} + {trim_reg[15], trim_reg}; // R8
    // trim saturates at both ends instead of wrapping
    wire logic [15:0] raw_mv   = !sum_mv[16] ? sum_mv[15:0] :
                                 (trim_reg[15] ? 16'h0000 : 16'hffff);
    wire logic [15:0] tgt_next = raw_mv > max_reg ? max_reg : raw_mv; // R9 R10

    // fault detection
    // OV watched while off too, so a persisting OV keeps the output down; UV watched only in ORS_ON
    wire logic ov_now = (state_reg != ORS_INIT) && vout_meas_mv > ovl_reg; // R11
    wire logic uv_now = (state_reg == ORS_ON) && vout_meas_mv < uvl_reg; // R14
    wire logic ov_sd  = ovr_reg == ORS_LATCH ? ov_latch_reg :
                        ovr_reg == ORS_WHILE ? ov_now :
                        ovr_reg == ORS_DELAY ? ov_latch_reg : 1'b0; // R12 R13
    wire logic uv_sd  = uvr_reg == ORS_LATCH ? uv_latch_reg :
                        uvr_reg == ORS_WHILE ? uv_now :
                        uvr_reg == ORS_DELAY ? uv_latch_reg : 1'b0;
    wire logic fault  = ov_sd || uv_sd || ov_now || uv_now;
    wire logic run    = req_on && !ov_sd && !uv_sd;

    wire logic wr_clr = bus_req.wr && bus_req.addr == `ORS_OFF_CLEAR;
    wire logic rise   = req_on && !req_on_reg; // R12

    // power good hysteresis
    wire logic pg_next = (state_reg == ORS_ON) && run && !fault &&
                         (pg_reg ? vout_meas_mv >= pgoff_reg : vout_meas_mv > pgon_reg); // R16 R17

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ORS_INIT: if (init_done) state_next = ORS_OFF; // R18
            ORS_OFF:  if (run && !track_reg) state_next = ORS_RAMP;
            ORS_RAMP: if (!run) state_next = ORS_OFF;
                      else if (vout_meas_mv > pgon_reg) state_next = ORS_CAL;
            ORS_CAL:  if (!run) state_next = ORS_OFF;
                      else if (cal_done) state_next = ORS_ON;
            ORS_ON:   if (!run) state_next = ORS_OFF;
            default:  state_next = ORS_INIT;
        endcase
    end

    // fault latch: event set wins over bus clear; re-enable clears too
    function automatic logic [16:0] fault_step(input logic now, input ors_resp_t r,
                                               input logic lat, input logic [15:0] cnt,
                                               input logic clr);
        logic       l;
        logic [15:0] c;
        l = lat;
        c = cnt;
        if (r == ORS_LATCH) begin
            l = now || (lat && !clr);
            c = 16'h0;
        end else if (r == ORS_DELAY) begin
            if (!now) begin
                c = 16'h0; // R21
                l = 1'b0;
            end else if (cnt >= 16'(DELAY_CYC - 1)) begin
                l = 1'b1;
            end else begin
                c = cnt + 16'h1;
            end
        end else begin
            l = 1'b0;
            c = 16'h0;
        end
        return {l, c};
    endfunction

    wire logic [16:0] ov_step = fault_step(ov_now, ovr_reg, ov_latch_reg, ov_cnt_reg, wr_clr || rise);
    wire logic [16:0] uv_step = fault_step(uv_now, uvr_reg, uv_latch_reg, uv_cnt_reg, wr_clr || rise);

    wire logic [15:0] status = {9'h0, track_reg, pg_reg, en_reg, uv_latch_reg, ov_latch_reg,
                                uv_now, ov_now};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ORS_INIT;
            op_reg    <= `ORS_OP_RESET;
            onoff_reg <= `ORS_ONOFF_RESET;
            nom_reg   <= 16'h0;
            cmd_reg   <= 16'h0;
            trim_reg  <= 16'h0;
            max_reg   <= 16'h0;
            mh_reg    <= 16'h0;
            ml_reg    <= 16'h0;
            ovl_reg   <= 16'h0;
            uvl_reg   <= 16'h0;
            pgon_reg  <= 16'h0;
            pgoff_reg <= 16'h0;
            ovr_reg   <= ORS_WHILE;
            uvr_reg   <= ORS_WHILE;
            track_reg <= 1'b0;
            ov_latch_reg <= 1'b0;
            uv_latch_reg <= 1'b0;
            ov_cnt_reg   <= 16'h0;
            uv_cnt_reg   <= 16'h0;
            pg_reg    <= 1'b0;
            pg_oe_reg <= 1'b1;
            req_on_reg <= 1'b1;
            en_reg    <= 1'b0;
            cal_ok_reg <= 1'b0;
            tgt_reg   <= 16'h0;
            rdata_reg <= 16'h0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ORS_INIT && init_done) begin
                // strap caught once, after reset release only
                nom_reg   <= load_nom; // R4
                cmd_reg   <= load_nom;
                track_reg <= strap_track && !nvm_cmd_valid; // R5
                max_reg   <= scale_pm(load_nom, `ORS_MAX_PM) < `ORS_ABS_MAX_MV ?
                             scale_pm(load_nom, `ORS_MAX_PM) : `ORS_ABS_MAX_MV; // R9
                mh_reg    <= scale_pm(load_nom, `ORS_MH_PM); // R7
                ml_reg    <= scale_pm(load_nom, `ORS_ML_PM);
                ovl_reg   <= scale_pm(load_nom, `ORS_OV_PM); // R11
                uvl_reg   <= scale_pm(load_nom, `ORS_UV_PM); // R14
                pgon_reg  <= scale_pm(load_nom, `ORS_PGON_PM); // R16
                pgoff_reg <= scale_pm(load_nom, `ORS_PGOFF_PM); // R17
            end else if (bus_req.wr) begin
                case (bus_req.addr)
                    `ORS_OFF_OPERATION:   op_reg    <= bus_req.wdata[2:0];
                    `ORS_OFF_ON_OFF_CFG:  onoff_reg <= bus_req.wdata[3:0];
                    `ORS_OFF_VOUT_CMD:    cmd_reg   <= bus_req.wdata; // R6
                    `ORS_OFF_VOUT_TRIM:   trim_reg  <= bus_req.wdata;
                    `ORS_OFF_VOUT_MAX:    max_reg   <= bus_req.wdata;
                    `ORS_OFF_MARGIN_HIGH: mh_reg    <= bus_req.wdata;
                    `ORS_OFF_MARGIN_LOW:  ml_reg    <= bus_req.wdata;
                    `ORS_OFF_OV_LIMIT:    ovl_reg   <= bus_req.wdata;
                    `ORS_OFF_OV_RESP:     ovr_reg   <= ors_resp_t'(bus_req.wdata[1:0]);
                    `ORS_OFF_UV_LIMIT:    uvl_reg   <= bus_req.wdata;
                    `ORS_OFF_UV_RESP:     uvr_reg   <= ors_resp_t'(bus_req.wdata[1:0]);
                    `ORS_OFF_PG_ON:       pgon_reg  <= bus_req.wdata;
                    `ORS_OFF_PG_OFF:      pgoff_reg <= bus_req.wdata;
                    default: ;
                endcase
            end
            ov_latch_reg <= ov_step[16];
            ov_cnt_reg   <= ov_step[15:0];
            uv_latch_reg <= uv_step[16];
            uv_cnt_reg   <= uv_step[15:0];
            en_reg     <= state_next != ORS_INIT && state_next != ORS_OFF;
            cal_ok_reg <= state_next == ORS_ON;
            pg_reg     <= pg_next; // R15
            pg_oe_reg  <= !pg_next;
            req_on_reg <= req_on;
            tgt_reg    <= tgt_next;
            case (bus_req.addr)
                `ORS_OFF_OPERATION:   rdata_reg <= {13'h0, op_reg};
                `ORS_OFF_ON_OFF_CFG:  rdata_reg <= {12'h0, onoff_reg};
                `ORS_OFF_VOUT_CMD:    rdata_reg <= cmd_reg;
                `ORS_OFF_VOUT_TRIM:   rdata_reg <= trim_reg;
                `ORS_OFF_VOUT_MAX:    rdata_reg <= max_reg;
                `ORS_OFF_MARGIN_HIGH: rdata_reg <= mh_reg;
                `ORS_OFF_MARGIN_LOW:  rdata_reg <= ml_reg;
                `ORS_OFF_OV_LIMIT:    rdata_reg <= ovl_reg;
                `ORS_OFF_OV_RESP:     rdata_reg <= {14'h0, ovr_reg};
                `ORS_OFF_UV_LIMIT:    rdata_reg <= uvl_reg;
                `ORS_OFF_UV_RESP:     rdata_reg <= {14'h0, uvr_reg};
                `ORS_OFF_PG_ON:       rdata_reg <= pgon_reg;
                `ORS_OFF_PG_OFF:      rdata_reg <= pgoff_reg;
                `ORS_OFF_STATUS:      rdata_reg <= status;
                `ORS_OFF_TARGET:      rdata_reg <= tgt_reg;
                default:              rdata_reg <= 16'h0;
            endcase
        end
    end

    assign bus_rdata            = rdata_reg;
    assign output_enable        = en_reg;
    assign target_mv            = tgt_reg;
    assign track_mode           = track_reg;
    // open drain: drive low unless good
    assign power_good_output_o  = 1'b0;
    assign power_good_output_oe = pg_oe_reg; // R15

    property p_pg_needs_cal;
        @(posedge clk) disable iff (!rst_n) pg_reg |-> cal_ok_reg;
    endproperty
    a_pg_needs_cal: assert property (p_pg_needs_cal) else $error("pg without calibration"); // R16

    property p_pg_low_in_fault;
        @(posedge clk) disable iff (!rst_n) (ov_now || uv_now) |=> !pg_reg;
    endproperty
    a_pg_low_in_fault: assert property (p_pg_low_in_fault) else $error("pg high in fault"); // R15

    property p_clamp;
        @(posedge clk) disable iff (!rst_n) ##1 tgt_reg <= $past(max_reg);
    endproperty
    a_clamp: assert property (p_clamp) else $error("target above max"); // R10

    property p_while_off;
        @(posedge clk) disable iff (!rst_n)
            (ovr_reg == ORS_WHILE && ov_now && state_reg != ORS_INIT) |=> !en_reg;
    endproperty
    a_while_off: assert property (p_while_off) else $error("output on during ov"); // R13

    property p_latch_holds;
        @(posedge clk) disable iff (!rst_n)
            (ov_latch_reg && ovr_reg == ORS_LATCH && !wr_clr && !rise) |=> ov_latch_reg;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("ov latch lost"); // R12

    property p_delay_cancel;
        @(posedge clk) disable iff (!rst_n)
            (ovr_reg == ORS_DELAY && !ov_now) |=> ov_cnt_reg == 16'h0;
    endproperty
    a_delay_cancel: assert property (p_delay_cancel) else $error("delay not cancelled"); // R21

    property p_strap_hold;
        @(posedge clk) disable iff (!rst_n)
            (state_reg != ORS_INIT) |=> nom_reg == $past(nom_reg);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("nominal changed"); // R4

    property p_pin_default;
        @(posedge clk) disable iff (!rst_n)
            (onoff_reg == `ORS_ONOFF_RESET && !on_off_pin && state_reg != ORS_INIT) |=> !en_reg;
    endproperty
    a_pin_default: assert property (p_pin_default) else $error("on with pin low"); // R1 R2

    property p_init_pg;
        @(posedge clk) disable iff (!rst_n) (state_reg == ORS_INIT) |-> !pg_reg;
    endproperty
    a_init_pg: assert property (p_init_pg) else $error("pg during init"); // R18

    // a latched fault holds the output off until cleared or re-enabled
    sequence s_ov_latched;
        ov_latch_reg && ovr_reg == ORS_LATCH;
    endsequence
    property p_latch_off;
        @(posedge clk) disable iff (!rst_n) s_ov_latched |=> !en_reg;
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("output on while latched"); // R12

    sequence s_pg_rise;
        !pg_reg ##1 pg_reg;
    endsequence
    property p_pg_rise_level;
        @(posedge clk) disable iff (!rst_n) s_pg_rise |-> $past(vout_meas_mv) > $past(pgon_reg);
    endproperty
    a_pg_rise_level: assert property (p_pg_rise_level) else $error("pg rose below level"); // R16
endmodule
`default_nettype wire

// *** ors_rail_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ors_rail_model (
    // switch and regulator controls
    input  wire logic        switch_closed,
    input  wire logic        output_enable,
    input  wire logic [15:0] target_mv,
    input  wire logic        power_good_output_oe,
    // disturbance forced onto the output by the bench
    input  wire logic        disturb,
    input  wire logic [15:0] disturb_mv,
    // levels seen by the block and the board
    output logic             on_off_pin,
    output logic [15:0]      vout_meas_mv,
    output logic             pg_line
);
    // internal pull-up holds the pin high while the switch is open;
    // no sync clock is fitted, so the switch may close at any time
    assign on_off_pin   = !switch_closed;
    // prompt regulator: output follows the target, collapses when off
    assign vout_meas_mv = disturb ? disturb_mv : (output_enable ? target_mv : 16'h0000);
    // open drain with board pull-up
    assign pg_line      = !power_good_output_oe;
endmodule
`default_nettype wire

// *** test_output_rail_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ors_cfg.svh"
module test_output_rail_supervisor;
    import ors_pkg::*;
    localparam int DLY = 4;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    ors_bus_req_t bus_req = '0;
    logic [15:0]  bus_rdata;
    logic [4:0]   strap = 5'h17;
    logic         nvm_valid = 1'b0;
    logic [15:0]  nvm_mv = 16'h0000;
    logic         cal_done = 1'b0;
    logic         init_done = 1'b0;
    logic         sw_closed = 1'b1;
    logic         disturb = 1'b0;
    logic [15:0]  disturb_mv = 16'h0000;
    logic         on_off_pin, output_enable, track_mode, pg_o, pg_oe, pg_line;
    logic [15:0]  vout, target_mv;
    int           n_errors = 0;
    int           checks = 0;

    ors_supervisor #(.DELAY_CYC(DLY)) u_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .setpoint_strap_pin(strap), .nvm_cmd_valid(nvm_valid),
        .nvm_cmd_mv(nvm_mv), .on_off_pin(on_off_pin), .vout_meas_mv(vout),
        .cal_done(cal_done), .init_done(init_done), .output_enable(output_enable),
        .target_mv(target_mv), .track_mode(track_mode), .power_good_output_o(pg_o),
        .power_good_output_oe(pg_oe));
    ors_rail_model u_rail (.switch_closed(sw_closed), .output_enable(output_enable),
        .target_mv(target_mv), .power_good_output_oe(pg_oe), .disturb(disturb),
        .disturb_mv(disturb_mv), .on_off_pin(on_off_pin), .vout_meas_mv(vout),
        .pg_line(pg_line));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 chk(what, exp, bus_rdata);
    endtask

    // bounded wait for output_enable, or for the power good pull-down enable, to reach the given level
    task automatic waitv(input bit pg, input logic v, input string what);
        int n;
        n = 0;
        #1;
        while ((pg ? pg_oe : output_enable) !== v && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk(what, {15'h0, v}, {15'h0, pg ? pg_oe : output_enable});
    endtask

    task automatic drive(input logic sw, input logic dis, input logic [15:0] mv);
        @(posedge clk);
        sw_closed  <= sw;
        disturb    <= dis;
        disturb_mv <= mv;
    endtask

    task automatic power_up(input logic [4:0] s, input logic nv, input logic [15:0] nmv);
        @(posedge clk);
        rst_n     <= 1'b0;
        init_done <= 1'b0;
        strap     <= s;
        nvm_valid <= nv;
        nvm_mv    <= nmv;
        drive(1'b1, 1'b0, 16'h0000);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("pg held low in init", 16'h1, {15'h0, pg_oe});
        @(posedge clk);
        init_done <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_defaults;
        rchk("on_off_config", `ORS_OFF_ON_OFF_CFG, 16'h0001);
        rchk("vout_command", `ORS_OFF_VOUT_CMD, 16'd1000);
        rchk("vout_max", `ORS_OFF_VOUT_MAX, 16'd1100);
        rchk("margin_high", `ORS_OFF_MARGIN_HIGH, 16'd1050);
        rchk("margin_low", `ORS_OFF_MARGIN_LOW, 16'd950);
        rchk("ov_limit", `ORS_OFF_OV_LIMIT, 16'd1150);
        rchk("ov_resp", `ORS_OFF_OV_RESP, 16'h0003);
        rchk("uv_limit", `ORS_OFF_UV_LIMIT, 16'd850);
        rchk("uv_resp", `ORS_OFF_UV_RESP, 16'h0003);
        rchk("pg_on", `ORS_OFF_PG_ON, 16'd900);
        rchk("pg_off", `ORS_OFF_PG_OFF, 16'd850);
        rchk("unmapped", 8'h40, 16'h0000);
        @(posedge clk);
        strap <= 5'h1e;
        repeat (4) @(posedge clk);
        rchk("cmd after strap change", `ORS_OFF_VOUT_CMD, 16'd1000);
        rchk("max after strap change", `ORS_OFF_VOUT_MAX, 16'd1100);
        @(posedge clk);
        strap <= 5'h17;
        $display("test defaults done");
    endtask

    task automatic t_enable;
        drive(1'b0, 1'b0, 16'h0000);
        waitv(0, 1'b1, "on by open pin");
        repeat (4) @(posedge clk);
        #1 chk("pg waits for calibration", 16'h1, {15'h0, pg_oe});
        @(posedge clk);
        cal_done <= 1'b1;
        waitv(1, 1'b0, "pg after calibration");
        chk("pg pin drives low only", 16'h0, {15'h0, pg_o});
        chk("pg line released high", 16'h1, {15'h0, pg_line});
        chk("target port", 16'd1000, target_mv);
        drive(1'b1, 1'b0, 16'h0000);
        waitv(0, 1'b0, "off by grounded pin");
        waitv(1, 1'b1, "pg low when off");
        wr(`ORS_OFF_ON_OFF_CFG, 16'h0005);
        waitv(0, 1'b1, "negative polarity on");
        wr(`ORS_OFF_ON_OFF_CFG, 16'h0002);
        waitv(0, 1'b0, "command only, off");
        wr(`ORS_OFF_OPERATION, 16'h0001);
        waitv(0, 1'b1, "command only, on");
        wr(`ORS_OFF_OPERATION, 16'h0000);
        waitv(0, 1'b0, "command only, off again");
        wr(`ORS_OFF_ON_OFF_CFG, 16'h0008);
        waitv(0, 1'b1, "always on");
        $display("test enable done");
    endtask

    task automatic t_target;
        wr(`ORS_OFF_VOUT_CMD, 16'd1050);
        rchk("target from command", `ORS_OFF_TARGET, 16'd1050);
        wr(`ORS_OFF_VOUT_TRIM, 16'd20);
        rchk("target trim up", `ORS_OFF_TARGET, 16'd1070);
        wr(`ORS_OFF_VOUT_TRIM, 16'hffe2);
        rchk("target trim down", `ORS_OFF_TARGET, 16'd1020);
        wr(`ORS_OFF_VOUT_TRIM, 16'h0000);
        rchk("target zero trim", `ORS_OFF_TARGET, 16'd1050);
        wr(`ORS_OFF_VOUT_CMD, 16'd1500);
        rchk("command kept whole", `ORS_OFF_VOUT_CMD, 16'd1500);
        rchk("target clamped", `ORS_OFF_TARGET, 16'd1100);
        chk("target port clamped", 16'd1100, target_mv);
        wr(`ORS_OFF_VOUT_MAX, 16'd1600);
        rchk("target new max", `ORS_OFF_TARGET, 16'd1500);
        wr(`ORS_OFF_VOUT_MAX, 16'd1100);
        wr(`ORS_OFF_VOUT_CMD, 16'd1000);
        wr(`ORS_OFF_OPERATION, 16'h0005);
        rchk("margin high", `ORS_OFF_TARGET, 16'd1050);
        wr(`ORS_OFF_OPERATION, 16'h0003);
        rchk("margin low", `ORS_OFF_TARGET, 16'd950);
        wr(`ORS_OFF_MARGIN_LOW, 16'd900);
        rchk("margin low set", `ORS_OFF_TARGET, 16'd900);
        wr(`ORS_OFF_OPERATION, 16'h0001);
        rchk("margin off", `ORS_OFF_TARGET, 16'd1000);
        $display("test target done");
    endtask

    task automatic t_faults;
        waitv(1, 1'b0, "running before faults");
        drive(1'b1, 1'b1, 16'd1200);
        waitv(0, 1'b0, "ov while present off");
        drive(1'b1, 1'b0, 16'h0000);
        waitv(0, 1'b1, "ov cleared resumes");
        wr(`ORS_OFF_OV_RESP, 16'h0000);
        drive(1'b1, 1'b1, 16'd1200);
        repeat (10) @(posedge clk);
        #1 chk("ov continue", 16'h1, {15'h0, output_enable});
        wr(`ORS_OFF_OV_RESP, 16'h0002);
        waitv(0, 1'b0, "ov latch off");
        drive(1'b1, 1'b0, 16'h0000);
        repeat (10) @(posedge clk);
        #1 chk("ov latch holds", 16'h0, {15'h0, output_enable});
        rchk("status latched", `ORS_OFF_STATUS, 16'h0004);
        wr(`ORS_OFF_CLEAR, 16'h0001);
        waitv(0, 1'b1, "ov latch cleared");
        waitv(1, 1'b0, "running again");
        wr(`ORS_OFF_OV_RESP, 16'h0001);
        drive(1'b1, 1'b1, 16'd1200);
        repeat (2) @(posedge clk);
        drive(1'b1, 1'b0, 16'h0000);
        repeat (10) @(posedge clk);
        #1 chk("short fault cancelled", 16'h1, {15'h0, output_enable});
        drive(1'b1, 1'b1, 16'd1200);
        repeat (2) @(posedge clk);
        #1 chk("delay still running", 16'h1, {15'h0, output_enable});
        chk("pg low in fault", 16'h1, {15'h0, pg_oe});
        waitv(0, 1'b0, "delayed shutdown");
        drive(1'b1, 1'b0, 16'h0000);
        wr(`ORS_OFF_OV_RESP, 16'h0003);
        wr(`ORS_OFF_CLEAR, 16'h0001);
        waitv(1, 1'b0, "running before uv");
        drive(1'b1, 1'b1, 16'd800);
        waitv(0, 1'b0, "uv while present off");
        drive(1'b1, 1'b0, 16'h0000);
        waitv(0, 1'b1, "uv cleared resumes");
        $display("test faults done");
    endtask

    task automatic t_reinit;
        power_up(5'h1f, 1'b0, 16'h0000);
        rchk("open strap", `ORS_OFF_VOUT_CMD, 16'h0000);
        power_up(5'h05, 1'b0, 16'h0000);
        chk("track strap", 16'h1, {15'h0, track_mode});
        power_up(5'h17, 1'b1, 16'd1800);
        rchk("stored command", `ORS_OFF_VOUT_CMD, 16'd1800);
        rchk("stored max", `ORS_OFF_VOUT_MAX, 16'd1980);
        chk("fixed regulation", 16'h0, {15'h0, track_mode});
        $display("test reinit done");
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial begin
        power_up(5'h17, 1'b0, 16'h0000);
        t_defaults();
        t_enable();
        t_target();
        t_faults();
        t_reinit();
        test_done();
    end
endmodule
`default_nettype wire
